// File: logic/isu_defs.svh
// Operation
// - A flag stays set until host writes one there; zero writes change nothing.
// - Bit 31 sets when host raises the software event trigger; write one clears.
// - Bit 25 sets once stop-transmit is requested and transmitter has halted.
// - Bit 24 sets when the receive engine halts.
// - Bit 23 sets when drop counter steps from 7FFFFFFFh to 80000000h.
// - Bit 21 sets when a notify-marked transmit buffer finishes loading.
// - Bit 20 sets when the programmed receive transfer count has been moved out.
// - Bit 19 sets when the timer counts past zero and wraps to FFFFh.
// - Bit 18 is read-only, mirrors the line interface event, ignores writes.
// - Bit 17 sets on a detected power event, even with the pin disabled.
// - Writing one to bit 17 clears it unless a power event is detected in the same cycle.
// - Power events never wake the device; any byte-test register write does.
// - The hold-off interval never delays or hides the power event interrupt.
// - Bit 16 sets when the transmit status FIFO overflows.
// - Bit 15 sets when a received packet is longer than 2048 bytes.
// - Bit 14 sets when the receive engine reports an error.
// - Bit 13 sets when the transmit engine reports an error.
// - Flags record events whatever the enable mask holds.
// - Master line is high while any enabled flag is active.
`ifndef ISU_DEFS_SVH
`define ISU_DEFS_SVH

`define ISU_ADDR_W          12
`define ISU_OFS_STATUS      12'h058
`define ISU_OFS_ENABLE      12'h05c
`define ISU_OFS_BYTE_TEST   12'h064
`define ISU_BYTE_TEST_VAL   32'h8765_4321
`define ISU_STATUS_RESET    32'h0000_0000
`define ISU_ENABLE_RESET    32'h0000_0000
`define ISU_FLAG_MASK       32'h83bb_e000
`define ISU_ENABLE_MASK     32'h83bf_e000
`define ISU_BIT_SW          31
`define ISU_BIT_TX_HALT     25
`define ISU_BIT_RX_HALT     24
`define ISU_BIT_DROP_MID    23
`define ISU_BIT_BUF_DONE    21
`define ISU_BIT_RX_XFER     20
`define ISU_BIT_TIMER       19
`define ISU_BIT_LINE        18
`define ISU_BIT_POWER       17
`define ISU_BIT_TXS_OVF     16
`define ISU_BIT_RX_WDOG     15
`define ISU_BIT_RX_ERR      14
`define ISU_BIT_TX_ERR      13
`define ISU_DROP_BEFORE     32'h7fff_ffff
`define ISU_DROP_AFTER      32'h8000_0000
`define ISU_TIMER_ZERO      16'h0000
`define ISU_TIMER_WRAP      16'hffff
`define ISU_LEN_W           14
`define ISU_RX_WDOG_LIMIT   14'h0800
`define ISU_EDGE_N          3

`endif

// File: logic/isu_pkg.sv
`default_nettype none
package isu_pkg;

    typedef enum logic [1:0] {
        ISU_ST_IDLE = 2'b01,
        ISU_ST_RESP = 2'b10
    } isu_bus_state_type;

endpackage
`default_nettype wire

// File: logic/isu_rise_det.sv
`timescale 1ns/100ps
`default_nettype none
`include "isu_defs.svh"

module isu_rise_det #(
    parameter int N = `ISU_EDGE_N
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // Levels and their rising edges
    input  wire logic [N-1:0] level_in,
    output logic      [N-1:0] rise_out
);

    logic [N-1:0] prev_q;
    logic [N-1:0] prev_d;

    always_comb begin
        prev_d = level_in;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // A level already high when reset releases counts as a rising edge.
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_bit
            assign rise_out[g] = level_in[g] & ~prev_q[g];
        end
    endgenerate

endmodule
`default_nettype wire

// File: logic/isu_top.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "isu_defs.svh"

module isu_top (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`ISU_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Event sources from the engines
    input  wire logic                    tx_stop_request,
    input  wire logic                    tx_halted,
    input  wire logic                    rx_halted,
    input  wire logic [31:0]             drop_count,
    input  wire logic                    buffer_loaded,
    input  wire logic                    completion_notify_marker,
    input  wire logic                    receive_transfer_done,
    input  wire logic [15:0]             timer_count,
    input  wire logic                    line_interface_event,
    input  wire logic                    power_event_detected,
    input  wire logic                    tx_status_overflow,
    input  wire logic                    rx_frame_end,
    input  wire logic [`ISU_LEN_W-1:0]   rx_frame_len,
    input  wire logic                    rx_error,
    input  wire logic                    tx_error,
    // Interrupt and wake outputs
    output logic                         irq_master,
    output logic                         power_event_irq,
    output logic                         wake_request
);

    // Bus state.
    isu_pkg::isu_bus_state_type st_q;
    isu_pkg::isu_bus_state_type st_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;

    // Register state.
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] enable_q;
    logic [31:0] enable_d;
    logic [31:0] drop_prev_q;
    logic [31:0] drop_prev_d;
    logic [15:0] timer_prev_q;
    logic [15:0] timer_prev_d;
    logic        irq_master_q;
    logic        irq_master_d;
    logic        power_irq_q;
    logic        power_irq_d;
    logic        wake_q;
    logic        wake_d;

    logic [31:0] status_view;
    logic [31:0] read_value;
    logic        addr_ok;
    logic        wr_commit;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [`ISU_EDGE_N-1:0] edge_level;
    logic [`ISU_EDGE_N-1:0] edge_rise;

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign irq_master      = irq_master_q;
    assign power_event_irq = power_irq_q;
    assign wake_request    = wake_q;

    // The line interface bit is never stored here, so only its source can clear it.
    always_comb begin
        status_view = status_q;
        status_view[`ISU_BIT_LINE] = line_interface_event;
    end

    always_comb begin
        addr_ok = (paddr == `ISU_OFS_STATUS) || (paddr == `ISU_OFS_ENABLE) ||
                  (paddr == `ISU_OFS_BYTE_TEST);
        case (paddr)
            `ISU_OFS_STATUS:    read_value = status_view;
            `ISU_OFS_ENABLE:    read_value = enable_q;
            `ISU_OFS_BYTE_TEST: read_value = `ISU_BYTE_TEST_VAL;
            default:            read_value = 32'h0000_0000;
        endcase
    end

    // Answer one cycle after the access phase opens; the write lands on the next edge, where pready is sampled high.
    always_comb begin
        st_d      = st_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        case (st_q)
            isu_pkg::ISU_ST_IDLE: begin
                if (psel && penable) begin
                    st_d      = isu_pkg::ISU_ST_RESP;
                    pready_d  = 1'b1;
                    pslverr_d = ~addr_ok;
                    prdata_d  = pwrite ? 32'h0000_0000 : read_value;
                end
            end
            isu_pkg::ISU_ST_RESP: begin
                st_d = isu_pkg::ISU_ST_IDLE;
            end
            default: begin
                st_d = isu_pkg::ISU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q      <= isu_pkg::ISU_ST_IDLE;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            st_q      <= st_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign wr_commit = (st_q == isu_pkg::ISU_ST_RESP) && psel && penable && pwrite;

    assign edge_level = {enable_q[`ISU_BIT_SW], tx_stop_request & tx_halted, rx_halted};

    isu_rise_det #(
        .N (`ISU_EDGE_N)
    ) u_rise (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .level_in (edge_level),
        .rise_out (edge_rise)
    );

    // Events set flags regardless of the enable mask, which gates both irq_master and power_event_irq.
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[`ISU_BIT_SW]       = edge_rise[2];
        set_vec[`ISU_BIT_TX_HALT]  = edge_rise[1];
        set_vec[`ISU_BIT_RX_HALT]  = edge_rise[0];
        set_vec[`ISU_BIT_DROP_MID] = (drop_prev_q == `ISU_DROP_BEFORE) &&
                                     (drop_count == `ISU_DROP_AFTER);
        set_vec[`ISU_BIT_BUF_DONE] = buffer_loaded & completion_notify_marker;
        set_vec[`ISU_BIT_RX_XFER]  = receive_transfer_done;
        set_vec[`ISU_BIT_TIMER]    = (timer_prev_q == `ISU_TIMER_ZERO) &&
                                     (timer_count == `ISU_TIMER_WRAP);
        set_vec[`ISU_BIT_POWER]    = power_event_detected;
        set_vec[`ISU_BIT_TXS_OVF]  = tx_status_overflow;
        set_vec[`ISU_BIT_RX_WDOG]  = rx_frame_end &&
                                     (rx_frame_len > `ISU_RX_WDOG_LIMIT);
        set_vec[`ISU_BIT_RX_ERR]   = rx_error;
        set_vec[`ISU_BIT_TX_ERR]   = tx_error;
    end

    always_comb begin
        clr_vec = 32'h0000_0000;
        if (wr_commit && (paddr == `ISU_OFS_STATUS)) begin
            clr_vec = pwdata & `ISU_FLAG_MASK;
        end
        status_d = ((status_q & ~clr_vec) | set_vec) & `ISU_FLAG_MASK;
        enable_d = enable_q;
        if (wr_commit && (paddr == `ISU_OFS_ENABLE)) begin
            enable_d = pwdata & `ISU_ENABLE_MASK;
        end
        drop_prev_d  = drop_count;
        timer_prev_d = timer_count;
        irq_master_d = |(status_view & enable_q);
        // No hold-off exists in this path, so the power interrupt is never delayed.
        power_irq_d  = status_q[`ISU_BIT_POWER] & enable_q[`ISU_BIT_POWER];
        wake_d       = wr_commit && (paddr == `ISU_OFS_BYTE_TEST);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status_q     <= `ISU_STATUS_RESET;
            enable_q     <= `ISU_ENABLE_RESET;
            drop_prev_q  <= 32'h0000_0000;
            timer_prev_q <= `ISU_TIMER_WRAP;
            irq_master_q <= 1'b0;
            power_irq_q  <= 1'b0;
            wake_q       <= 1'b0;
        end else begin
            status_q     <= status_d;
            enable_q     <= enable_d;
            drop_prev_q  <= drop_prev_d;
            timer_prev_q <= timer_prev_d;
            irq_master_q <= irq_master_d;
            power_irq_q  <= power_irq_d;
            wake_q       <= wake_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic status_clr_wr;
    assign status_clr_wr = wr_commit && (paddr == `ISU_OFS_STATUS);

    flag_hold_a: assert property (
        (status_q[`ISU_BIT_RX_ERR] && !(status_clr_wr && pwdata[`ISU_BIT_RX_ERR]))
        |=> status_q[`ISU_BIT_RX_ERR])
        else $error("error flag dropped without a clear");

    flag_clear_a: assert property (
        (status_clr_wr && pwdata[`ISU_BIT_POWER] && !power_event_detected)
        |=> !status_q[`ISU_BIT_POWER])
        else $error("power flag not cleared by write one");

    sw_trigger_a: assert property (
        (wr_commit && (paddr == `ISU_OFS_ENABLE) && pwdata[`ISU_BIT_SW] &&
         !enable_q[`ISU_BIT_SW]) |=> ##1 status_q[`ISU_BIT_SW])
        else $error("software flag not set after trigger");

    tx_halt_a: assert property (
        $rose(tx_stop_request && tx_halted) |=> status_q[`ISU_BIT_TX_HALT])
        else $error("transmit halt flag missing");

    drop_mid_a: assert property (
        (drop_count == `ISU_DROP_BEFORE) ##1 (drop_count == `ISU_DROP_AFTER)
        |=> status_q[`ISU_BIT_DROP_MID])
        else $error("drop midpoint flag missing");

    timer_wrap_a: assert property (
        (timer_count == `ISU_TIMER_ZERO) ##1 (timer_count == `ISU_TIMER_WRAP)
        |=> status_q[`ISU_BIT_TIMER])
        else $error("timer wrap flag missing");

    watchdog_set_a: assert property (
        (rx_frame_end && (rx_frame_len > `ISU_RX_WDOG_LIMIT)) |=> status_q[`ISU_BIT_RX_WDOG])
        else $error("watchdog flag missing for long frame");

    line_mirror_a: assert property (
        (st_q == isu_pkg::ISU_ST_IDLE && psel && penable && !pwrite &&
         paddr == `ISU_OFS_STATUS) |=> prdata_q[`ISU_BIT_LINE] == $past(line_interface_event))
        else $error("line interface bit does not mirror its source");

    wake_cause_a: assert property (
        wake_q |-> $past(wr_commit) && ($past(paddr) == `ISU_OFS_BYTE_TEST))
        else $error("wake without byte test write");

    power_no_wake_a: assert property (
        (power_event_detected && !wr_commit) |=> !wake_q)
        else $error("power event caused a wake");

    reserved_zero_a: assert property (
        (status_q & ~`ISU_FLAG_MASK) == 32'h0000_0000)
        else $error("reserved status bits not zero");

    set_wins_a: assert property (
        (status_clr_wr && pwdata[`ISU_BIT_TX_ERR] && tx_error) |=> status_q[`ISU_BIT_TX_ERR])
        else $error("event lost against a clear");

    irq_line_a: assert property (
        ##1 (irq_master_q == $past(|(status_view & enable_q))))
        else $error("master line does not follow enabled flags");

    power_irq_a: assert property (
        (status_q[`ISU_BIT_POWER] && enable_q[`ISU_BIT_POWER]) |=> power_irq_q && irq_master_q)
        else $error("power interrupt delayed");

    mask_free_a: assert property (
        (rx_halted && !$past(rx_halted) && !enable_q[`ISU_BIT_RX_HALT])
        |=> status_q[`ISU_BIT_RX_HALT])
        else $error("masked event not recorded");

    rx_halt_a: assert property (
        $rose(rx_halted) |=> status_q[`ISU_BIT_RX_HALT])
        else $error("receive halt flag missing");

    buf_done_a: assert property (
        (buffer_loaded && completion_notify_marker) |=> status_q[`ISU_BIT_BUF_DONE])
        else $error("buffer completion flag missing");

    rx_xfer_a: assert property (
        receive_transfer_done |=> status_q[`ISU_BIT_RX_XFER])
        else $error("receive transfer flag missing");

    power_set_a: assert property (
        power_event_detected |=> status_q[`ISU_BIT_POWER])
        else $error("power event flag missing");

    status_ovf_a: assert property (
        tx_status_overflow |=> status_q[`ISU_BIT_TXS_OVF])
        else $error("status overflow flag missing");

    read_cov_c: cover property (
        st_q == isu_pkg::ISU_ST_RESP && !pwrite && paddr == `ISU_OFS_STATUS);
    clear_cov_c: cover property (status_q[`ISU_BIT_POWER] ##1 status_clr_wr ##1
        !status_q[`ISU_BIT_POWER]);
    irq_cov_c: cover property ($rose(irq_master_q));
    wake_cov_c: cover property (wake_q);

endmodule
`default_nettype wire

// File: test/isu_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "isu_defs.svh"

module isu_engine_model (
    // Commands from the bench
    input  wire logic                  go,
    input  wire logic [2:0]            sel,
    input  wire logic                  long_frame,
    // Engine events
    output logic                       buffer_loaded,
    output logic                       completion_notify_marker,
    output logic                       receive_transfer_done,
    output logic                       power_event_detected,
    output logic                       tx_status_overflow,
    output logic                       rx_frame_end,
    output logic [`ISU_LEN_W-1:0]      rx_frame_len,
    output logic                       rx_error,
    output logic                       tx_error
);
    // Pulses are combinational so that the bench alone decides their cycle.
    assign buffer_loaded            = go && (sel == 3'h0);
    // The long-frame switch also drives the notify marker, so one switch covers both
    // negative cases.
    assign completion_notify_marker = long_frame;
    assign receive_transfer_done    = go && (sel == 3'h1);
    assign power_event_detected     = go && (sel == 3'h2);
    assign tx_status_overflow       = go && (sel == 3'h3);
    assign rx_frame_end             = go && (sel == 3'h4);
    assign rx_error                 = go && (sel == 3'h5);
    assign tx_error                 = go && (sel == 3'h6);
    // Outside a frame end the length is garbage, so a stale value is never shown.
    assign rx_frame_len = !rx_frame_end ? 14'h37fe : (long_frame ? 14'h0801 : 14'h0800);
endmodule
`default_nettype wire

// File: test/tb_isu_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "isu_defs.svh"

module tb_isu_top;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq_master, power_event_irq, wake_request, last_err;
    logic        tx_stop_request = 1'b0, tx_halted = 1'b0, rx_halted = 1'b0;
    logic        line_interface_event = 1'b0, go = 1'b0, long_frame = 1'b1;
    logic [2:0]  sel = 3'h0;
    logic [31:0] drop_count = 32'h7fff_ffff;
    logic [15:0] timer_count = 16'h0000;
    logic        buffer_loaded, completion_notify_marker, receive_transfer_done;
    logic        power_event_detected, tx_status_overflow, rx_frame_end, rx_error, tx_error;
    logic [13:0] rx_frame_len;
    int          n_errors = 0, n_compared = 0, n_wake = 0;
    int          bits [11] = '{21, 20, 17, 16, 15, 14, 13, 25, 24, 23, 19};

    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wake_request === 1'b1) n_wake++;

    isu_engine_model u_eng (.go(go), .sel(sel), .long_frame(long_frame),
        .buffer_loaded(buffer_loaded), .completion_notify_marker(completion_notify_marker),
        .receive_transfer_done(receive_transfer_done), .power_event_detected(power_event_detected),
        .tx_status_overflow(tx_status_overflow), .rx_frame_end(rx_frame_end),
        .rx_frame_len(rx_frame_len), .rx_error(rx_error), .tx_error(tx_error));

    isu_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_stop_request(tx_stop_request), .tx_halted(tx_halted),
        .rx_halted(rx_halted), .drop_count(drop_count), .buffer_loaded(buffer_loaded),
        .completion_notify_marker(completion_notify_marker),
        .receive_transfer_done(receive_transfer_done), .timer_count(timer_count),
        .line_interface_event(line_interface_event), .power_event_detected(power_event_detected),
        .tx_status_overflow(tx_status_overflow), .rx_frame_end(rx_frame_end),
        .rx_frame_len(rx_frame_len), .rx_error(rx_error), .tx_error(tx_error),
        .irq_master(irq_master), .power_event_irq(power_event_irq), .wake_request(wake_request));

    task automatic conclude;
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !done; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) done = 1'b1;
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            check(32'h0, 32'h1, "pready");
            conclude;
        end
    endtask

    task automatic rd_status(input logic [31:0] exp, input string what);
        apb(1'b0, `ISU_OFS_STATUS, 32'h0);
        check(rd, exp, what);
    endtask

    // Engine pulses go through the model; level sources are stepped here.
    task automatic fire(input int k);
        case (k)
            7: begin tx_stop_request <= 1'b1; tx_halted <= 1'b1; end
            8: rx_halted <= 1'b1;
            9: drop_count <= 32'h8000_0000;
            10: timer_count <= 16'hffff;
            default: begin sel <= 3'(k); go <= 1'b1; end
        endcase
        @(posedge clk_sys);
        go <= 1'b0; tx_stop_request <= 1'b0; tx_halted <= 1'b0; rx_halted <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_status(32'h0, "status reset");
        apb(1'b0, `ISU_OFS_ENABLE, 32'h0);
        check(rd, 32'h0, "enable reset");
        apb(1'b0, `ISU_OFS_BYTE_TEST, 32'h0);
        check(rd, 32'h8765_4321, "byte test");
        apb(1'b0, 12'h060, 32'h0);
        check({31'h0, last_err}, 32'h1, "unmapped error");
        apb(1'b1, `ISU_OFS_STATUS, 32'h7c40_0000);
        rd_status(32'h0, "reserved write");
        for (int k = 0; k < 11; k++) begin
            fire(k);
            if (k < 3) rd_status(32'h1 << bits[k], "event flag");
            else if (k < 5) rd_status(32'h1 << bits[k], "event flag");
            else if (k < 7) rd_status(32'h1 << bits[k], "event flag");
            else if (k < 9) rd_status(32'h1 << bits[k], "event flag");
            else rd_status(32'h1 << bits[k], "event flag");
            check({31'h0, irq_master}, 32'h0, "masked irq");
            apb(1'b1, `ISU_OFS_STATUS, 32'h0);
            rd_status(32'h1 << bits[k], "zero write");
            apb(1'b1, `ISU_OFS_STATUS, 32'hffff_ffff);
            rd_status(32'h0, "one clear");
        end
        long_frame <= 1'b0;
        fire(4);
        rd_status(32'h0, "frame of 2048");
        fire(0);
        rd_status(32'h0, "unmarked buffer");
        apb(1'b1, `ISU_OFS_ENABLE, 32'h8000_0000);
        repeat (3) @(posedge clk_sys);
        check({31'h0, irq_master}, 32'h1, "master line");
        rd_status(32'h8000_0000, "software flag");
        apb(1'b1, `ISU_OFS_STATUS, 32'h8000_0000);
        rd_status(32'h0, "software clear");
        repeat (2) @(posedge clk_sys);
        check({31'h0, irq_master}, 32'h0, "master idle");
        line_interface_event <= 1'b1;
        repeat (2) @(posedge clk_sys);
        apb(1'b1, `ISU_OFS_STATUS, 32'hffff_ffff);
        rd_status(32'h0004_0000, "line mirror");
        line_interface_event <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd_status(32'h0, "line release");
        apb(1'b1, `ISU_OFS_ENABLE, 32'h0002_0000);
        fire(2);
        check({31'h0, power_event_irq}, 32'h1, "power irq");
        check(n_wake, 32'h0, "no wake on power event");
        apb(1'b1, `ISU_OFS_STATUS, 32'h0002_0000);
        repeat (2) @(posedge clk_sys);
        check({31'h0, power_event_irq}, 32'h0, "power clear");
        apb(1'b1, `ISU_OFS_BYTE_TEST, 32'h0);
        repeat (3) @(posedge clk_sys);
        check(n_wake, 32'h1, "wake on write");
        // The error stays high through the clearing edge and drops right after it.
        sel <= 3'h6;
        go <= 1'b1;
        apb(1'b1, `ISU_OFS_STATUS, 32'h0000_2000);
        go <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd_status(32'h0000_2000, "event beats clear");
        conclude;
    end
endmodule
`default_nettype wire
